// ===== shared/cmrt_consts.vh
// Constants for the compare, move, reverse and test datapath
`ifndef CMRT_CONSTS_VH
`define CMRT_CONSTS_VH
// Register byte offsets
`define CMRT_OFS_OPA 8'h00
`define CMRT_OFS_OPB 8'h04
`define CMRT_OFS_SHF 8'h08
`define CMRT_OFS_IMM 8'h0C
`define CMRT_OFS_DST 8'h10
`define CMRT_OFS_CMD 8'h14
`define CMRT_OFS_RES 8'h18
`define CMRT_OFS_FLG 8'h1C
`define CMRT_OFS_STA 8'h20
`define CMRT_OFS_TGT 8'h24
// Command fields
`define CMRT_CMD_OP 3:0
`define CMRT_CMD_SETF 4
`define CMRT_CMD_PASS 5
`define CMRT_CMD_TOPC 6
// Shift control fields
`define CMRT_SHF_TYPE 2:0
`define CMRT_SHF_IMMOP 3
`define CMRT_SHF_BYREG 4
`define CMRT_SHF_IAMT 13:8
`define CMRT_SHF_RAMT 23:16
// Flag word position, order N Z C V
`define CMRT_FLG_POS 31:28
// Operation codes
`define CMRT_OP_CMPSUB 4'h0
`define CMRT_OP_CMPADD 4'h1
`define CMRT_OP_COPY 4'h2
`define CMRT_OP_COPYINV 4'h3
`define CMRT_OP_WIDEIMM 4'h4
`define CMRT_OP_UPPER 4'h5
`define CMRT_OP_SWAPW 4'h6
`define CMRT_OP_SWAPH 4'h7
`define CMRT_OP_SWAPSX 4'h8
`define CMRT_OP_BITFLIP 4'h9
`define CMRT_OP_ANDTST 4'hA
`define CMRT_OP_XORTST 4'hB
// Shift types
`define CMRT_SH_LSL 3'h0
`define CMRT_SH_LSR 3'h1
`define CMRT_SH_ASR 3'h2
`define CMRT_SH_ROR 3'h3
`define CMRT_SH_RRX 3'h4
// Reset values
`define CMRT_RST_WORD 32'h00000000
`define CMRT_RST_FLAGS 4'h0
`endif

// ===== verilog/cmrt_alu.v
// Compare, move, reverse and test execution datapath with a Wishbone slave
// Contract
// RULE1 - compare_subtract: flags from difference, no write
// RULE2 - compare_add: flags from sum, result discarded
// RULE3 - Compares always update N Z C V
// RULE4 - Decoder avoids program_counter, stack_pointer flex_operand
// RULE5 - copy_operand writes shifted flex_operand unchanged
// RULE6 - copy accepts zero-extended half_word_immediate
// RULE7 - Register-shifted copy equals standalone shift
// RULE8 - copy_inverted writes complement of flex_operand
// RULE9 - stack_pointer/program_counter only in plain copy
// RULE10 - Copy to program_counter clears bit0, branches
// RULE11 - Copies with flags: N Z, shifter C, V kept
// RULE12 - load_upper_half sets bits 31:16, keeps rest
// RULE13 - Decoder avoids upper load to stack_pointer/program_counter
// RULE14 - byte_swap_word reverses the four bytes
// RULE15 - byte_swap_halves swaps bytes within each half
// RULE16 - Swap low half bytes, sign-extend to word
// RULE17 - bit_order_flip mirrors all 32 bits
// RULE18 - Swaps and bit flip leave flags unchanged
// RULE19 - and_test: AND sets flags, result discarded
// RULE20 - xor_test: XOR sets flags, result discarded
// RULE21 - Tests: N Z, shifter C, keep V
// RULE22 - Failed condition writes nothing at all; the code still loads res_r and sta_r
// RULE23 - Copies without flag request keep all flags
`default_nettype none
`include "cmrt_consts.vh"

module cmrt_alu #(
	parameter ADR_W = 8
) (
	// Clock, reset and freeze
	input wire mclk,
	input wire rst_n,
	input wire clkEn,
	// Wishbone classic slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Towards the register file and fetch
	output reg destWe,
	output reg [31:0] destData,
	output reg branchTaken,
	output reg [31:0] branchAddr,
	output reg [3:0] flagsOut
);

	// ****************************************
	// Storage
	// ****************************************
	reg [31:0] opA_r;
	reg [31:0] opB_r;
	reg [31:0] shf_r;
	reg [31:0] imm_r;
	reg [31:0] dst_r;
	reg [31:0] cmd_r;
	reg [31:0] res_r;
	reg [3:0] sta_r;
	reg go_r;

	// Byte-lane merge for partial writes
	function [31:0] laneMerge;
		input [31:0] oldV;
		input [31:0] newV;
		input [3:0] sel;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				laneMerge[k*8 +: 8] = sel[k] ? newV[k*8 +: 8] : oldV[k*8 +: 8];
			end
		end
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	wire busReq = wb_cyc_i & wb_stb_i;
	// Writes commit only on the edge where the master sees ack
	wire busCommit = busReq & wb_ack_o & wb_we_i;
	wire [7:0] adr8 = wb_adr_i[7:0];

	// ****************************************
	// Operand shifter
	// ****************************************
	wire [2:0] shType = shf_r[`CMRT_SHF_TYPE];
	wire [7:0] shAmt = shf_r[`CMRT_SHF_BYREG] ? shf_r[`CMRT_SHF_RAMT] : {2'h0, shf_r[`CMRT_SHF_IAMT]};
	wire flagC = flagsOut[1];
	wire flagV = flagsOut[0];
	reg [63:0] lslW;
	reg [32:0] lsrW;
	reg signed [32:0] asrW;
	reg [63:0] rorW;
	reg [31:0] flexVal;
	reg flexC;

	// Shifts beyond 32 fall out of the wide LSL, LSR and ASR forms and ROR takes the amount modulo 32, so no clamping is needed
	always @* begin
		lslW = {32'h00000000, opB_r} << shAmt;
		lsrW = {opB_r, 1'b0} >> shAmt;
		asrW = $signed({opB_r, 1'b0}) >>> shAmt;
		rorW = {opB_r, opB_r} >> shAmt[4:0];
		flexVal = opB_r;
		flexC = flagC;
		if (shf_r[`CMRT_SHF_IMMOP]) begin
			flexVal = imm_r;
		end else if (shType == `CMRT_SH_RRX) begin
			flexVal = {flagC, opB_r[31:1]};
			flexC = opB_r[0];
		end else if (shAmt != 8'h00) begin
			case (shType)
				`CMRT_SH_LSL: begin
					flexVal = lslW[31:0];
					flexC = lslW[32];
				end
				`CMRT_SH_LSR: begin
					flexVal = lsrW[32:1];
					flexC = lsrW[0];
				end
				`CMRT_SH_ASR: begin
					flexVal = asrW[32:1];
					flexC = asrW[0];
				end
				`CMRT_SH_ROR: begin
					flexVal = rorW[31:0];
					flexC = rorW[31];
				end
				default: begin
					flexVal = opB_r;
					flexC = flagC;
				end
			endcase
		end
	end

	// ****************************************
	// Reversal networks
	// ****************************************
	wire [31:0] flipW;
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : gFlip
			assign flipW[gi] = opB_r[31-gi]; // RULE17
		end
	endgenerate
	wire [31:0] swapW = {opB_r[7:0], opB_r[15:8], opB_r[23:16], opB_r[31:24]}; // RULE14
	wire [31:0] swapH = {opB_r[23:16], opB_r[31:24], opB_r[7:0], opB_r[15:8]}; // RULE15
	wire [31:0] swapS = {{16{opB_r[7]}}, opB_r[7:0], opB_r[15:8]}; // RULE16

	// ****************************************
	// Operation select and flag logic
	// ****************************************
	wire [3:0] opCode = cmd_r[`CMRT_CMD_OP];
	wire setF = cmd_r[`CMRT_CMD_SETF];
	reg [32:0] sumW;
	reg [31:0] resV;
	reg [3:0] flagsNew;
	reg wrDest;
	reg updFlags;
	reg isBranch;

	always @* begin
		sumW = 33'h000000000;
		resV = 32'h00000000;
		wrDest = 1'b1;
		updFlags = 1'b0;
		isBranch = 1'b0;
		flagsNew = flagsOut;
		case (opCode)
			`CMRT_OP_CMPSUB: begin
				// Carry is the inverse of borrow
				sumW = {1'b0, opA_r} + {1'b0, ~flexVal} + 33'h000000001; // RULE1
				resV = sumW[31:0];
				wrDest = 1'b0;
				updFlags = 1'b1; // RULE3
				flagsNew = {resV[31], resV == 32'h00000000, sumW[32],
					(opA_r[31] != flexVal[31]) & (resV[31] != opA_r[31])};
			end
			`CMRT_OP_CMPADD: begin
				sumW = {1'b0, opA_r} + {1'b0, flexVal}; // RULE2
				resV = sumW[31:0];
				wrDest = 1'b0;
				updFlags = 1'b1; // RULE3
				flagsNew = {resV[31], resV == 32'h00000000, sumW[32],
					(opA_r[31] == flexVal[31]) & (resV[31] != opA_r[31])};
			end
			`CMRT_OP_COPY: begin
				resV = flexVal; // RULE5 RULE7
				updFlags = setF; // RULE23
				flagsNew = {resV[31], resV == 32'h00000000, flexC, flagV}; // RULE11
				isBranch = cmd_r[`CMRT_CMD_TOPC]; // RULE10
			end
			`CMRT_OP_COPYINV: begin
				resV = ~flexVal; // RULE8
				updFlags = setF; // RULE23
				flagsNew = {resV[31], resV == 32'h00000000, flexC, flagV}; // RULE11
			end
			`CMRT_OP_WIDEIMM: begin
				resV = {16'h0000, imm_r[15:0]}; // RULE6
			end
			`CMRT_OP_UPPER: begin
				resV = {imm_r[15:0], dst_r[15:0]}; // RULE12
			end
			`CMRT_OP_SWAPW: begin
				resV = swapW; // RULE18
			end
			`CMRT_OP_SWAPH: begin
				resV = swapH; // RULE18
			end
			`CMRT_OP_SWAPSX: begin
				resV = swapS; // RULE18
			end
			`CMRT_OP_BITFLIP: begin
				resV = flipW; // RULE18
			end
			`CMRT_OP_ANDTST: begin
				resV = opA_r & flexVal; // RULE19
				wrDest = 1'b0;
				updFlags = 1'b1;
				flagsNew = {resV[31], resV == 32'h00000000, flexC, flagV}; // RULE21
			end
			`CMRT_OP_XORTST: begin
				resV = opA_r ^ flexVal; // RULE20
				wrDest = 1'b0;
				updFlags = 1'b1;
				flagsNew = {resV[31], resV == 32'h00000000, flexC, flagV}; // RULE21
			end
			default: begin
				// Unknown codes write no destination, flags or branch; res_r takes zero and sta_r still loads
				wrDest = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Read mux
	// ****************************************
	reg [31:0] rdMux;
	always @* begin
		case (adr8)
			`CMRT_OFS_OPA: rdMux = opA_r;
			`CMRT_OFS_OPB: rdMux = opB_r;
			`CMRT_OFS_SHF: rdMux = shf_r;
			`CMRT_OFS_IMM: rdMux = imm_r;
			`CMRT_OFS_DST: rdMux = dst_r;
			`CMRT_OFS_CMD: rdMux = cmd_r;
			`CMRT_OFS_RES: rdMux = res_r;
			`CMRT_OFS_FLG: rdMux = {flagsOut, 28'h0000000};
			`CMRT_OFS_STA: rdMux = {28'h0000000, sta_r};
			`CMRT_OFS_TGT: rdMux = branchAddr;
			default: rdMux = 32'h00000000;
		endcase
	end

	// ****************************************
	// Bus slave and execution state
	// ****************************************
	// One wait state: ack rises the cycle after the request, drops after one
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `CMRT_RST_WORD;
			opA_r <= `CMRT_RST_WORD;
			opB_r <= `CMRT_RST_WORD;
			shf_r <= `CMRT_RST_WORD;
			imm_r <= `CMRT_RST_WORD;
			dst_r <= `CMRT_RST_WORD;
			cmd_r <= `CMRT_RST_WORD;
			res_r <= `CMRT_RST_WORD;
			sta_r <= 4'h0;
			go_r <= 1'b0;
			flagsOut <= `CMRT_RST_FLAGS;
			destWe <= 1'b0;
			destData <= `CMRT_RST_WORD;
			branchTaken <= 1'b0;
			branchAddr <= `CMRT_RST_WORD;
		end else if (clkEn) begin
			wb_ack_o <= busReq & ~wb_ack_o;
			if (busReq & ~wb_ack_o) begin
				wb_dat_o <= rdMux;
			end
			go_r <= 1'b0;
			destWe <= 1'b0;
			branchTaken <= 1'b0;
			if (busCommit) begin
				case (adr8)
					`CMRT_OFS_OPA: opA_r <= laneMerge(opA_r, wb_dat_i, wb_sel_i);
					`CMRT_OFS_OPB: opB_r <= laneMerge(opB_r, wb_dat_i, wb_sel_i);
					`CMRT_OFS_SHF: shf_r <= laneMerge(shf_r, wb_dat_i, wb_sel_i);
					`CMRT_OFS_IMM: imm_r <= laneMerge(imm_r, wb_dat_i, wb_sel_i);
					`CMRT_OFS_DST: dst_r <= laneMerge(dst_r, wb_dat_i, wb_sel_i);
					`CMRT_OFS_CMD: begin
						// A command write launches the operation next cycle
						cmd_r <= laneMerge(cmd_r, wb_dat_i, wb_sel_i);
						go_r <= 1'b1;
					end
					`CMRT_OFS_FLG: begin
						if (wb_sel_i[3]) begin
							flagsOut <= wb_dat_i[`CMRT_FLG_POS];
						end
					end
					default: begin
						// Read-only and unmapped words ignore writes
					end
				endcase
			end
			// Bus cannot commit in a go cycle, so no write races the result
			if (go_r) begin
				res_r <= resV;
				sta_r <= {~cmd_r[`CMRT_CMD_PASS], updFlags, isBranch, wrDest & ~isBranch};
				if (cmd_r[`CMRT_CMD_PASS]) begin // RULE22
					if (updFlags) begin
						flagsOut <= flagsNew;
					end
					if (isBranch) begin
						branchTaken <= 1'b1;
						branchAddr <= {resV[31:1], 1'b0}; // RULE10
					end else if (wrDest) begin
						destWe <= 1'b1;
						destData <= resV;
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== verification/cmrt_alu_props.sv
// Checker for the compare, move, reverse and test datapath
`default_nettype none
`include "cmrt_consts.vh"
module cmrt_alu_props #(parameter ADR_W = 8) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Execution
	input wire logic destWe,
	input wire logic branchTaken,
	input wire logic [31:0] branchAddr,
	input wire logic [3:0] flagsOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Command commit, its opcode and its pass bit
	// A frozen edge commits nothing, so the enable qualifies every commit
	wire logic cmdWr = clkEn && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `CMRT_OFS_CMD;
	wire logic [3:0] op = wb_dat_i[3:0];
	wire logic ok = wb_dat_i[5];
	AST_ACK_ONE: assert property (clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_PULSE: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_WE_CAUSE: assert property (destWe |-> $past(cmdWr && ok, 1) || $past(cmdWr && ok, 2))
		else $error("dest write without passed command");
	AST_BR: assert property (branchTaken |-> !branchAddr[0] && !destWe && $past(cmdWr && wb_dat_i[6], 2))
		else $error("bad branch");
	AST_NO_DEST: assert property (cmdWr && (op < 4'h2 || op == 4'hA || op == 4'hB)
		|=> (!destWe && !branchTaken)[*2])
		else $error("compare or test wrote");
	AST_SWAP_FLAGS: assert property (cmdWr && op >= 4'h5 && op <= 4'h9 |=> $stable(flagsOut)[*2])
		else $error("flags moved");
	AST_COPY_NOFLAG: assert property (cmdWr && !wb_dat_i[4] && op >= 4'h2 && op <= 4'h4
		|=> $stable(flagsOut)[*2])
		else $error("flags moved without request");
	AST_KEEP_V: assert property (cmdWr && (op == 4'h2 || op == 4'h3 || op == 4'hA || op == 4'hB)
		|=> $stable(flagsOut[0]) ##1 $stable(flagsOut[0]))
		else $error("overflow changed");
	AST_FAIL_FLAGS: assert property (cmdWr && !ok |=> $stable(flagsOut)[*2])
		else $error("failed command moved flags");
endmodule
bind cmrt_alu cmrt_alu_props #(.ADR_W(ADR_W)) u_props (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.destWe(destWe), .branchTaken(branchTaken), .branchAddr(branchAddr), .flagsOut(flagsOut));
`default_nettype wire

// ===== verification/cmrt_dec_model.sv
// Decoder and register file model issuing operations over the bus
`default_nettype none
`include "cmrt_consts.vh"
module cmrt_dec_model (
	// Clock and answer
	input wire logic mclk,
	input wire logic ack,
	input wire logic [31:0] datI,
	// Request
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h00000000;
	end
	// One classic cycle; released data is inverted so stale values never pass
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		@(posedge mclk);
		while (ack !== 1'b1) @(posedge mclk);
		q = datI;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		dat <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		access(1'b0, a, 32'h00000000, q);
	endtask
	// Operands first, command last; pointer forms only as plain unshifted copy
	task automatic exec(input logic [31:0] a, b, s, i, d, c);
		wr(`CMRT_OFS_OPA, a);
		wr(`CMRT_OFS_OPB, b);
		wr(`CMRT_OFS_SHF, s);
		wr(`CMRT_OFS_IMM, i);
		wr(`CMRT_OFS_DST, d);
		wr(`CMRT_OFS_CMD, c);
	endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the compare, move, reverse and test datapath
`default_nettype none
`include "cmrt_consts.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %0t got %0h exp %0h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, clkEn, wbCyc, wbStb, wbWe, wbAck, destWe, branchTaken, seenWe, seenBr;
	logic [7:0] wbAdr;
	logic [3:0] wbSel, flagsOut;
	logic [31:0] wbDatW, wbDatR, destData, branchAddr, rdv;
	int n_fail, n_checks, cycles;
	cmrt_alu u_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
		.wb_ack_o(wbAck), .destWe(destWe), .destData(destData), .branchTaken(branchTaken),
		.branchAddr(branchAddr), .flagsOut(flagsOut));
	cmrt_dec_model u_dec (.mclk(mclk), .ack(wbAck), .datI(wbDatR), .cyc(wbCyc), .stb(wbStb), .we(wbWe),
		.adr(wbAdr), .sel(wbSel), .dat(wbDatW));
	task results();
		if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Issue one operation, watch three cycles, compare; ctl is topc, pass, setf
	task automatic run(input logic [3:0] op, input logic [2:0] ctl, input logic [31:0] a, b, s, i, d, res,
		input logic [3:0] f);
		u_dec.exec(a, b, s, i, d, {25'h0, ctl, op});
		seenWe = 1'b0;
		seenBr = 1'b0;
		repeat (3) begin
			#1;
			seenWe = seenWe | destWe;
			seenBr = seenBr | branchTaken;
			@(posedge mclk);
		end
		`CHK(seenWe, ctl[1] & ~ctl[2] & (op >= 4'h2 && op <= 4'h9))
		if (seenWe === 1'b1) `CHK(destData, res)
		`CHK(flagsOut, f)
	endtask
	// Clock, and a hang limit far above the expected run
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		u_dec.rd(`CMRT_OFS_FLG, rdv);
		`CHK(rdv, 32'h0)
		u_dec.wr(`CMRT_OFS_FLG, 32'h30000000);
		run(`CMRT_OP_CMPSUB, 3'b010, 32'h5, 0, 32'h8, 32'h5, 0, 0, 4'h6);
		run(`CMRT_OP_CMPADD, 3'b010, 32'h7FFFFFFF, 0, 32'h8, 32'h1, 0, 0, 4'h9);
		run(`CMRT_OP_COPY, 3'b011, 0, 32'h80000018, 32'h00040011, 0, 0, 32'h08000001, 4'h3);
		run(`CMRT_OP_COPYINV, 3'b011, 0, 0, 32'h8, 32'hF, 0, 32'hFFFFFFF0, 4'hB);
		run(`CMRT_OP_WIDEIMM, 3'b010, 0, 0, 0, 32'hABCDFFFF, 0, 32'h0000FFFF, 4'hB);
		run(`CMRT_OP_COPY, 3'b010, 0, 0, 0, 0, 0, 0, 4'hB);
		run(`CMRT_OP_UPPER, 3'b010, 0, 0, 0, 32'hF123, 32'h12345678, 32'hF1235678, 4'hB);
		run(`CMRT_OP_SWAPW, 3'b010, 0, 32'h123480AB, 0, 0, 0, 32'hAB803412, 4'hB);
		run(`CMRT_OP_SWAPH, 3'b010, 0, 32'h123480AB, 0, 0, 0, 32'h3412AB80, 4'hB);
		run(`CMRT_OP_SWAPSX, 3'b010, 0, 32'h123480AB, 0, 0, 0, 32'hFFFFAB80, 4'hB);
		run(`CMRT_OP_BITFLIP, 3'b010, 0, 32'h123480AB, 0, 0, 0, 32'hD5012C48, 4'hB);
		run(`CMRT_OP_ANDTST, 3'b010, 32'h0F, 0, 32'h8, 32'hF0, 0, 0, 4'h7);
		run(`CMRT_OP_XORTST, 3'b010, 32'h80000000, 0, 32'h8, 32'h7FFFFFFF, 0, 0, 4'hB);
		run(`CMRT_OP_COPY, 3'b001, 0, 0, 0, 0, 0, 0, 4'hB);
		run(`CMRT_OP_COPY, 3'b110, 0, 32'h1001, 0, 0, 0, 0, 4'hB);
		`CHK(seenBr, 1'b1)
		`CHK(branchAddr, 32'h1000)
		u_dec.rd(8'h3C, rdv);
		`CHK(rdv, 32'h0)
		// Remaining shift kinds through the copy path, then a borrowing compare
		run(`CMRT_OP_COPY, 3'b011, 0, 32'h1000000F, 32'h00000400, 0, 0, 32'h000000F0, 4'h3);
		run(`CMRT_OP_COPY, 3'b011, 0, 32'h80000080, 32'h00080012, 0, 0, 32'hFF800000, 4'hB);
		run(`CMRT_OP_COPY, 3'b011, 0, 32'h00000001, 32'h00000403, 0, 0, 32'h10000000, 4'h1);
		run(`CMRT_OP_COPY, 3'b011, 0, 32'h00000003, 32'h00000004, 0, 0, 32'h00000001, 4'h3);
		run(`CMRT_OP_CMPSUB, 3'b010, 32'h0, 0, 32'h8, 32'h1, 0, 0, 4'h8);
		// Low enable must hold off the bus answer and every flop
		clkEn <= 1'b0;
		fork
			u_dec.wr(`CMRT_OFS_FLG, 32'hC0000000);
			begin
				repeat (6) @(posedge mclk);
				`CHK(wbAck, 1'b0)
				`CHK(flagsOut, 4'h8)
				clkEn <= 1'b1;
			end
		join
		@(posedge mclk);
		`CHK(flagsOut, 4'hC)
		results();
	end
endmodule
`default_nettype wire
